//--- hw/sci_params.svh
// Constants of the serial baud and flag block
// Assumes it is included by both modules
//
// Notes on behaviour
// (R1) Prescaler divides by 1, 3, 4, 13, 39
// (R2) Rate divider divides by 1 to 128
// (R3) Dividers give sample clock; bit clock is sixteenth
// (R4) Rate select survives reset, writable anytime
// (R5) Software keeps low prescale bits zero with 39
// (R6) Flags set by hardware, cleared by software
// (R7) Enabling transmitter sets empty and done flags
// (R8) Empty flag with enable requests interrupt
// (R9) Done flag with enable requests interrupt
// (R10) Disabling transmitter finishes current character first
// (R11) Idle disable frees pin on bit clock
// (R12) Disable mid-character drops queued characters
// (R13) Last character end still sets both flags
// (R14) Overrun drops new character, sets overrun flag
// (R15) Buffer load sets receive full flag
// (R16) Noise and framing flags never interrupt
// (R17) Idle means one character time of ones
// (R18) Quiet flag set only on active-to-idle
// (R19) Status read then data write clears transmit flags
// (R20) Status read then data read clears receive flags
// (R21) Receive interrupt on full or overrun
// (R22) Enable queues one idle character preamble
// (R23) All requests ORed into one output
// (R24) Quiet flag with enable requests interrupt

`ifndef SCI_PARAMS_SVH
`define SCI_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SCI_ADDR_CTRL   2'h0
`define SCI_ADDR_BAUD   2'h1
`define SCI_ADDR_STATUS 2'h2
`define SCI_ADDR_DATA   2'h3

// ----------------------------------------
// Control and baud field positions
// ----------------------------------------
`define SCI_CB_EMPTY_IE 3'h7
`define SCI_CB_DONE_IE  3'h6
`define SCI_CB_RX_IE    3'h5
`define SCI_CB_QUIET_IE 3'h4
`define SCI_CB_TX_ON    3'h3
`define SCI_BB_PRE_HI   3'h6
`define SCI_BB_PRE_LO   3'h4
`define SCI_BB_RATE_HI  3'h2
`define SCI_BB_RATE_LO  3'h0

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define SCI_SB_EMPTY    3'h7
`define SCI_SB_DONE     3'h6
`define SCI_SB_FULL     3'h5
`define SCI_SB_QUIET    3'h4
`define SCI_SB_OVR      3'h3
`define SCI_SB_NOISE    3'h2
`define SCI_SB_FRAME    3'h1

// ----------------------------------------
// Divider codes and terminal counts
// ----------------------------------------
`define SCI_PRE_SEL_3   3'h1
`define SCI_PRE_SEL_4   3'h2
`define SCI_PRE_SEL_13  3'h3
`define SCI_PRE_SEL_39  3'h4
`define SCI_PRE_LAST_1  6'h00
`define SCI_PRE_LAST_3  6'h02
`define SCI_PRE_LAST_4  6'h03
`define SCI_PRE_LAST_13 6'h0C
`define SCI_PRE_LAST_39 6'h26
`define SCI_RT_LAST     4'hF
`define SCI_CHAR_LAST   4'h9
`define SCI_IDLE_BITS   4'hA

// ----------------------------------------
// Reset and idle values
// ----------------------------------------
`define SCI_FRAME_ONES  10'h3FF
`define SCI_LINE_IDLE   1'h1

`endif

//--- hw/sci_pkg.sv
// Types shared by the serial baud and flag modules
// Assumes sci_params.svh is on the include path

package sci_pkg;

  // Transmit shifter state
  typedef enum logic [0:0] {
    SCI_TX_IDLE  = 1'b0,
    SCI_TX_SHIFT = 1'b1
  } sci_tx_state_t;

  // Baud chain state
  typedef struct packed {
    logic [5:0] preCnt;
    logic [6:0] rateCnt;
    logic [3:0] rtCnt;
    logic       rtTick;
    logic       bitTick;
  } sci_baud_t;

  // Flag block state
  typedef struct packed {
    logic          rxSync1;
    logic          rxSync2;
    logic          txOn;
    logic          txOnPrev;
    logic          emptyIe;
    logic          doneIe;
    logic          rxIe;
    logic          quietIe;
    logic [2:0]    prescaleSel;
    logic [2:0]    rateSel;
    logic          txEmpty;
    logic          txDone;
    logic          rxFull;
    logic          rxQuiet;
    logic          overrun;
    logic          noise;
    logic          framing;
    logic [7:0]    armed;
    logic [7:0]    txHolding;
    logic          holdFull;
    logic          prePending;
    sci_tx_state_t txState;
    logic [9:0]    txShift;
    logic [3:0]    txBitCnt;
    logic          pinDrive;
    logic [7:0]    rxBuffer;
    logic          rxActive;
    logic [3:0]    idleCnt;
    logic          irq;
    logic [7:0]    rdData;
  } sci_state_t;

endpackage

//--- hw/sci_baud_gen.sv
// Baud chain: prescaler, binary rate divider, divide by sixteen
// Assumes one clock and a synchronous active-low reset

`timescale 1ns/1ps

`include "sci_params.svh"

module sci_baud_gen import sci_pkg::*; (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Rate selection
  input  wire logic [2:0] prescaleSel,
  input  wire logic [2:0] rateSel,
  // Tick pulses
  output logic            rtTick,
  output logic            bitTick
);

  // ----------------------------------------
  // Divider decoding
  // ----------------------------------------

  // Terminal count of the prescaler; undecoded codes run at full rate
  function automatic logic [5:0] preLast(input logic [2:0] sel);
    case (sel)
      `SCI_PRE_SEL_3:  preLast = `SCI_PRE_LAST_3;
      `SCI_PRE_SEL_4:  preLast = `SCI_PRE_LAST_4;
      `SCI_PRE_SEL_13: preLast = `SCI_PRE_LAST_13;
      `SCI_PRE_SEL_39: preLast = `SCI_PRE_LAST_39;
      default:         preLast = `SCI_PRE_LAST_1;
    endcase
  endfunction

  sci_baud_t  b_reg;     // Chain state
  sci_baud_t  b_next;    // Next chain state
  logic [6:0] rateLast;  // Rate terminal count

  // Each rate code doubles the divisor
  assign rateLast = 7'((8'h01 << rateSel) - 8'h01);

  // ----------------------------------------
  // Counter chain
  // ----------------------------------------

  // Counters compare with >= so a new selection never stalls the chain
  always_comb begin
    b_next = b_reg;
    b_next.rtTick = 1'b0;
    b_next.bitTick = 1'b0;
    if (b_reg.preCnt >= preLast(prescaleSel)) begin  // [R1]
      b_next.preCnt = 6'h00;
      if (b_reg.rateCnt >= rateLast) begin  // [R2]
        b_next.rateCnt = 7'h00;
        b_next.rtTick = 1'b1;  // [R3]
        b_next.rtCnt = b_reg.rtCnt + 4'h1;
        b_next.bitTick = (b_reg.rtCnt == `SCI_RT_LAST);  // [R3]
      end else begin
        b_next.rateCnt = b_reg.rateCnt + 7'h01;
      end
    end else begin
      b_next.preCnt = b_reg.preCnt + 6'h01;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      b_reg <= '0;
    end else begin
      b_reg <= b_next;
    end
  end

  assign rtTick  = b_reg.rtTick;
  assign bitTick = b_reg.bitTick;

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic [13:0] gapCnt;   // Cycles since last sample tick
  logic        gapSeen;  // A tick seen under the present selection
  logic [5:0]  selPrev;  // Selection one cycle ago
  logic [13:0] gapExp;   // Expected tick spacing less one

  assign gapExp = 14'((14'(preLast(prescaleSel)) + 14'h0001)
                      * (14'(rateLast) + 14'h0001) - 14'h0001);

  // Helper counter for the period check
  always_ff @(posedge clock) begin
    selPrev <= {prescaleSel, rateSel};
    if (!nrst || selPrev != {prescaleSel, rateSel}) begin
      gapCnt <= 14'h0000;
      gapSeen <= 1'b0;
    end else if (rtTick) begin
      gapCnt <= 14'h0000;
      gapSeen <= 1'b1;
    end else begin
      gapCnt <= gapCnt + 14'h0001;
    end
  end

  rt_period_a: assert property (rtTick && gapSeen && selPrev == {prescaleSel, rateSel}  // [R1]
                                |-> gapCnt == gapExp)
    else $error("sample tick spacing differs from divider product");
  bit_tick_a: assert property (bitTick |-> rtTick && $past(b_reg.rtCnt) == `SCI_RT_LAST)  // [R3]
    else $error("bit tick not on sixteenth sample tick");
  slow_cov: cover property (rtTick && prescaleSel == `SCI_PRE_SEL_39);

endmodule

//--- hw/sci_serial_flags.sv
// Serial interface baud chain, transmit shutdown and status flags
// Assumes a same-clock receiver hands over whole characters,
// and software follows the status-then-data clearing order

`timescale 1ns/1ps

`include "sci_params.svh"

module sci_serial_flags import sci_pkg::*; (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Register port
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  // Receiver character hand-off
  input  wire logic       rxCharValid,
  input  wire logic [7:0] rxCharData,
  input  wire logic       rxCharNoise,
  input  wire logic       rxCharFrameErr,
  // Serial pins
  input  wire logic       rxLine,
  output logic            txPinOut,
  output logic            txPinOeN,
  // Timing and interrupt
  output logic            rxSampleClock,
  output logic            sciIrq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------

  sci_state_t s_reg;     // All block state
  sci_state_t s_next;    // Next block state
  logic       rtTick;    // Sample clock tick
  logic       bitTick;   // Bit clock tick

  // Status word as software sees it
  function automatic logic [7:0] statusWord(input sci_state_t st);
    logic [7:0] w;
    w = 8'h00;
    w[`SCI_SB_EMPTY] = st.txEmpty;
    w[`SCI_SB_DONE]  = st.txDone;
    w[`SCI_SB_FULL]  = st.rxFull;
    w[`SCI_SB_QUIET] = st.rxQuiet;
    w[`SCI_SB_OVR]   = st.overrun;
    w[`SCI_SB_NOISE] = st.noise;
    w[`SCI_SB_FRAME] = st.framing;
    return w;
  endfunction

  // ----------------------------------------
  // Baud chain
  // ----------------------------------------

  // Prescaler, rate divider and bit divider
  sci_baud_gen u_baud (
    .clock       (clock),
    .nrst        (nrst),
    .prescaleSel (s_reg.prescaleSel),
    .rateSel     (s_reg.rateSel),
    .rtTick      (rtTick),
    .bitTick     (bitTick)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  always_comb begin
    s_next = s_reg;

    // Receive pin passes two flops before use
    s_next.rxSync1 = rxLine;
    s_next.rxSync2 = s_reg.rxSync1;
    s_next.txOnPrev = s_reg.txOn;
    s_next.rdData = 8'h00;

    // Register writes
    if (regWrite) begin
      if (regAddr == `SCI_ADDR_CTRL) begin
        s_next.emptyIe = regWrData[`SCI_CB_EMPTY_IE];
        s_next.doneIe  = regWrData[`SCI_CB_DONE_IE];
        s_next.rxIe    = regWrData[`SCI_CB_RX_IE];
        s_next.quietIe = regWrData[`SCI_CB_QUIET_IE];
        s_next.txOn    = regWrData[`SCI_CB_TX_ON];
      end else if (regAddr == `SCI_ADDR_BAUD) begin
        // Undecoded prescale codes are software's to avoid [R5]
        s_next.prescaleSel = regWrData[`SCI_BB_PRE_HI:`SCI_BB_PRE_LO];
        s_next.rateSel = regWrData[`SCI_BB_RATE_HI:`SCI_BB_RATE_LO];  // [R4]
      end else if (regAddr == `SCI_ADDR_DATA) begin
        // Data write ends the transmit clearing sequence [R19]
        if (s_reg.armed[`SCI_SB_EMPTY]) begin
          s_next.txEmpty = 1'b0;
        end
        if (s_reg.armed[`SCI_SB_DONE]) begin
          s_next.txDone = 1'b0;
        end
        s_next.armed[`SCI_SB_EMPTY] = 1'b0;
        s_next.armed[`SCI_SB_DONE]  = 1'b0;
        // Holding register only fills while transmitting
        if (s_reg.txOn) begin
          s_next.txHolding = regWrData;
          s_next.holdFull = 1'b1;
        end
      end
    end

    // Register reads, answered one cycle later
    if (regRead) begin
      if (regAddr == `SCI_ADDR_CTRL) begin
        s_next.rdData[`SCI_CB_EMPTY_IE] = s_reg.emptyIe;
        s_next.rdData[`SCI_CB_DONE_IE]  = s_reg.doneIe;
        s_next.rdData[`SCI_CB_RX_IE]    = s_reg.rxIe;
        s_next.rdData[`SCI_CB_QUIET_IE] = s_reg.quietIe;
        s_next.rdData[`SCI_CB_TX_ON]    = s_reg.txOn;
      end else if (regAddr == `SCI_ADDR_BAUD) begin
        s_next.rdData[`SCI_BB_PRE_HI:`SCI_BB_PRE_LO] = s_reg.prescaleSel;
        s_next.rdData[`SCI_BB_RATE_HI:`SCI_BB_RATE_LO] = s_reg.rateSel;
      end else if (regAddr == `SCI_ADDR_STATUS) begin
        // Status read arms every flag now set [R6]
        s_next.rdData = statusWord(s_reg);
        s_next.armed = statusWord(s_reg);
      end else begin
        // Data read ends the receive clearing sequence [R20]
        s_next.rdData = s_reg.rxBuffer;
        if (s_reg.armed[`SCI_SB_FULL]) begin
          s_next.rxFull = 1'b0;
        end
        if (s_reg.armed[`SCI_SB_QUIET]) begin
          s_next.rxQuiet = 1'b0;
        end
        if (s_reg.armed[`SCI_SB_OVR]) begin
          s_next.overrun = 1'b0;
        end
        if (s_reg.armed[`SCI_SB_NOISE]) begin
          s_next.noise = 1'b0;
        end
        if (s_reg.armed[`SCI_SB_FRAME]) begin
          s_next.framing = 1'b0;
        end
        s_next.armed = s_next.armed & 8'hC0;
      end
    end

    // Hardware sets follow the clears so that a set always wins

    // Transmitter switched on
    if (s_reg.txOn && !s_reg.txOnPrev) begin
      s_next.txEmpty = 1'b1;  // [R7]
      s_next.txDone = 1'b1;  // [R7]
      s_next.prePending = 1'b1;  // [R22]
    end

    // Transmitter switched off: queue is lost
    if (!s_reg.txOn) begin
      s_next.holdFull = 1'b0;  // [R12]
      s_next.prePending = 1'b0;  // [R12]
    end

    // Transmit shifter, one bit per bit tick
    if (bitTick) begin
      if (s_reg.txState == SCI_TX_SHIFT && s_reg.txBitCnt != `SCI_CHAR_LAST) begin
        // Current character runs on regardless of the enable [R10]
        s_next.txShift = {1'b1, s_reg.txShift[9:1]};
        s_next.txBitCnt = s_reg.txBitCnt + 4'h1;
      end else begin
        s_next.txState = SCI_TX_IDLE;
        s_next.txBitCnt = 4'h0;
        s_next.txShift = `SCI_FRAME_ONES;
        if (s_reg.txOn && s_reg.prePending) begin
          // Idle preamble: a whole frame of ones [R22]
          s_next.txState = SCI_TX_SHIFT;
          s_next.prePending = 1'b0;
        end else if (s_reg.txOn && s_reg.holdFull) begin
          // Stop bit, data LSB first, start bit
          s_next.txState = SCI_TX_SHIFT;
          s_next.txShift = {1'b1, s_reg.txHolding, 1'b0};
          s_next.holdFull = 1'b0;
          s_next.txEmpty = 1'b1;
        end else if (s_reg.txState == SCI_TX_SHIFT) begin
          // Queue drained or transmitter stopped
          s_next.txDone = 1'b1;  // [R13]
          if (!s_reg.txOn) begin
            s_next.txEmpty = 1'b1;  // [R13]
          end
        end
      end
      // Pin is handed back only on a bit tick [R11]
      s_next.pinDrive = s_reg.txOn || (s_next.txState == SCI_TX_SHIFT);
    end

    // Character hand-off from the receive shifter
    if (rxCharValid) begin
      if (s_next.rxFull) begin
        // Buffer still unread: new character is lost [R14]
        s_next.overrun = 1'b1;
      end else begin
        s_next.rxBuffer = rxCharData;
        s_next.rxFull = 1'b1;  // [R15]
        s_next.noise = s_next.noise | rxCharNoise;  // [R16]
        s_next.framing = s_next.framing | rxCharFrameErr;  // [R16]
      end
    end

    // Idle line detection on the synchronised pin
    if (!s_reg.rxSync2) begin
      s_next.rxActive = 1'b1;
      s_next.idleCnt = 4'h0;
    end else if (bitTick && s_reg.idleCnt != `SCI_IDLE_BITS) begin
      s_next.idleCnt = s_reg.idleCnt + 4'h1;  // [R17]
      if (s_next.idleCnt == `SCI_IDLE_BITS && s_reg.rxActive) begin
        s_next.rxQuiet = 1'b1;  // [R18]
        s_next.rxActive = 1'b0;
      end
    end

    // Single interrupt request; noise and framing excluded [R16]
    s_next.irq = (s_next.txEmpty && s_next.emptyIe)  // [R8]
               || (s_next.txDone && s_next.doneIe)  // [R9]
               || ((s_next.rxFull || s_next.overrun) && s_next.rxIe)  // [R21]
               || (s_next.rxQuiet && s_next.quietIe);  // [R23] [R24]
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Rate select keeps its value through reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.rxSync1 <= `SCI_LINE_IDLE;
      s_reg.rxSync2 <= `SCI_LINE_IDLE;
      s_reg.txShift <= `SCI_FRAME_ONES;
      s_reg.rateSel <= s_reg.rateSel;  // [R4]
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  assign regRdData     = s_reg.rdData;
  assign txPinOut      = s_reg.txShift[0];
  assign txPinOeN      = !s_reg.pinDrive;
  assign rxSampleClock = rtTick;
  assign sciIrq        = s_reg.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Enable and interrupt request checks
  tx_on_rise_a: assert property (s_reg.txOn && !s_reg.txOnPrev  // [R7]
                                 |=> s_reg.txEmpty && s_reg.txDone && s_reg.prePending)
    else $error("enabling transmitter did not set flags and preamble");
  empty_irq_a: assert property (s_reg.txEmpty && s_reg.emptyIe |-> sciIrq)  // [R8]
    else $error("empty flag did not raise interrupt");
  done_irq_a: assert property (s_reg.txDone && s_reg.doneIe |-> sciIrq)  // [R9]
    else $error("done flag did not raise interrupt");
  rx_irq_a: assert property ((s_reg.rxFull || s_reg.overrun) && s_reg.rxIe |-> sciIrq)  // [R21]
    else $error("receive flag did not raise interrupt");
  quiet_irq_a: assert property (s_reg.rxQuiet && s_reg.quietIe |-> sciIrq)  // [R24]
    else $error("quiet flag did not raise interrupt");
  irq_cause_a: assert property (sciIrq |-> (s_reg.txEmpty && s_reg.emptyIe)  // [R16] [R23]
                                || (s_reg.txDone && s_reg.doneIe)
                                || ((s_reg.rxFull || s_reg.overrun) && s_reg.rxIe)
                                || (s_reg.rxQuiet && s_reg.quietIe))
    else $error("interrupt without an enabled flag");
  // Shutdown and pin ownership
  finish_char_a: assert property (s_reg.txState == SCI_TX_SHIFT && !s_reg.txOn  // [R10]
                                  |=> s_reg.txState == SCI_TX_SHIFT
                                      || (s_reg.txDone && s_reg.txEmpty))
    else $error("stopped transmitter did not finish with flags set");
  queue_drop_a: assert property (!s_reg.txOn |=> !s_reg.holdFull)  // [R12]
    else $error("queued character kept after disable");
  pin_sync_a: assert property ($changed(s_reg.pinDrive) |-> $past(bitTick))  // [R11]
    else $error("pin ownership changed off the bit clock");
  // Receive hand-off, idle line and flag clearing
  rx_load_a: assert property (rxCharValid && !s_reg.rxFull  // [R15]
                              |=> s_reg.rxFull && s_reg.rxBuffer == $past(rxCharData))
    else $error("character not loaded into buffer");
  overrun_a: assert property (rxCharValid && s_reg.rxFull && !regRead  // [R14]
                              |=> s_reg.overrun && $stable(s_reg.rxBuffer))
    else $error("overrun did not keep buffer and set flag");
  quiet_edge_a: assert property ($rose(s_reg.rxQuiet)  // [R18]
                                 |-> $past(s_reg.rxActive) && s_reg.idleCnt == `SCI_IDLE_BITS)
    else $error("quiet flag set without activity and full idle time");
  full_clear_a: assert property ($fell(s_reg.rxFull)  // [R20]
                                 |-> $past(regRead && regAddr == `SCI_ADDR_DATA))
    else $error("receive full cleared without a data read");
  empty_clear_a: assert property (regWrite && regAddr == `SCI_ADDR_DATA  // [R19]
                                  && s_reg.armed[`SCI_SB_EMPTY] && !bitTick
                                  && !(s_reg.txOn && !s_reg.txOnPrev) |=> !s_reg.txEmpty)
    else $error("clearing sequence left empty flag set");

  // Flag sources and clearing sequences
  full_src_a: assert property ($rose(s_reg.rxFull) |-> $past(rxCharValid))  // [R6] [R15]
    else $error("receive full set without a character");
  overrun_src_a: assert property ($rose(s_reg.overrun)  // [R14]
                                  |-> $past(rxCharValid && s_reg.rxFull))
    else $error("overrun set without a blocked character");
  noise_src_a: assert property ($rose(s_reg.noise) || $rose(s_reg.framing)  // [R16]
                                |-> $past(rxCharValid && (rxCharNoise || rxCharFrameErr)))
    else $error("error flag set without a flagged character");
  quiet_src_a: assert property ($rose(s_reg.rxQuiet)  // [R17]
                                |-> $past(bitTick && s_reg.rxSync2))
    else $error("quiet flag set off an idle bit tick");
  tx_clear_a: assert property ($fell(s_reg.txEmpty) || $fell(s_reg.txDone)  // [R19]
                               |-> $past(regWrite && regAddr == `SCI_ADDR_DATA))
    else $error("transmit flag cleared without a data write");
  rx_clear_a: assert property ($fell(s_reg.rxQuiet) || $fell(s_reg.overrun)  // [R20]
                               |-> $past(regRead && regAddr == `SCI_ADDR_DATA))
    else $error("receive flag cleared without a data read");

  // Preamble start and pin release
  preamble_a: assert property (bitTick && s_reg.txOn && s_reg.prePending  // [R22]
                               && s_reg.txState == SCI_TX_IDLE
                               |=> s_reg.txState == SCI_TX_SHIFT
                                   && s_reg.txShift == `SCI_FRAME_ONES)
    else $error("preamble did not start as a frame of ones");
  pin_free_a: assert property (!s_reg.pinDrive  // [R11]
                               |-> txPinOut && s_reg.txState == SCI_TX_IDLE)
    else $error("pin released while a character shifts");

  // Main scenarios reached
  overrun_cov: cover property (rxCharValid && s_reg.rxFull);
  preamble_cov: cover property (bitTick && s_reg.prePending && s_reg.txOn);
  quiet_cov: cover property ($rose(s_reg.rxQuiet));
  stop_cov: cover property (s_reg.txState == SCI_TX_SHIFT && !s_reg.txOn
                            ##1 s_reg.txState == SCI_TX_IDLE);

endmodule

//--- dv/sci_remote_peer.sv
// Far-side serial device: pulls the receive line low for one bit
// Assumes the fastest baud setting, sixteen clocks per bit

`timescale 1ns/1ps

module sci_remote_peer (
  // Clock, reset and trigger
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic goActive,
  // Line toward the block
  output logic      rxLine
);
  logic [4:0] lowCnt;  // Cycles of low level left

  // One bit of activity, then the line is left at its pull-up level
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lowCnt <= 5'h00;
    end else if (goActive) begin
      lowCnt <= 5'h10;
    end else if (lowCnt != 5'h00) begin
      lowCnt <= lowCnt - 5'h01;
    end
  end

  // Released line idles high
  assign rxLine = (lowCnt == 5'h00);
endmodule

//--- dv/sci_serial_flags_test.sv
// Self-checking bench of the serial baud and flag block
// Assumes the register map and timing of the block hand-over

`timescale 1ns/1ps

module sci_serial_flags_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       clock, nrst, regWrite, regRead, goActive;
  logic [1:0] regAddr;
  logic [7:0] regWrData, regRdData, rxCharData;
  logic       rxCharValid, rxCharNoise, rxCharFrameErr, rxLine;
  logic       txPinOut, txPinOeN, rxSampleClock, sciIrq;
  int         mismatches, nTests, n;

  sci_serial_flags DUT (.clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .rxCharValid(rxCharValid), .rxCharData(rxCharData),
    .rxCharNoise(rxCharNoise), .rxCharFrameErr(rxCharFrameErr), .rxLine(rxLine),
    .txPinOut(txPinOut), .txPinOeN(txPinOeN), .rxSampleClock(rxSampleClock),
    .sciIrq(sciIrq));
  sci_remote_peer PEER (.clock(clock), .nrst(nrst), .goActive(goActive), .rxLine(rxLine));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare one value, count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Register write, one idle cycle after; returns once outputs settle
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Register read, data judged in the following cycle
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdData & m, e);
    @(posedge clock);
    #1;
  endtask

  // Cycles up to the next sample tick, bounded
  task automatic tick;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rxSampleClock !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      mismatches++;
      finish_test;
    end
  endtask

  // Hand over one received character
  task automatic rxc(input logic [7:0] d, input logic nz, input logic fe);
    rxCharValid <= 1'b1;
    rxCharData <= d;
    rxCharNoise <= nz;
    rxCharFrameErr <= fe;
    @(posedge clock);
    rxCharValid <= 1'b0;
    rxCharNoise <= 1'b0;
    rxCharFrameErr <= 1'b0;
    @(posedge clock);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Sample tick period over prescale and rate codes
  task automatic baud_chk(input logic [2:0] p, input logic [2:0] r, input logic [7:0] e);
    wr(2'h1, {1'b0, p, 1'b0, r});
    tick;
    tick;
    chk(n[7:0], e);
  endtask

  // Enable transmitter, then clear the empty flag
  task automatic tx_scn;
    wr(2'h0, 8'h88);
    chk({7'h00, sciIrq}, 8'h01);
    rd(2'h2, 8'h80, 8'h80);
    wr(2'h3, 8'h55);
    rd(2'h2, 8'h00, 8'h80);
    chk({7'h00, sciIrq}, 8'h00);
    n = 0;
    while (txPinOeN !== 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    #1 chk({6'h00, txPinOeN, txPinOut}, 8'h01);
  endtask

  // Full, overrun, then the clearing read
  task automatic rx_scn;
    wr(2'h0, 8'h30);
    rxc(8'h5A, 1'b1, 1'b0);
    rd(2'h2, 8'h24, 8'h2C);
    chk({7'h00, sciIrq}, 8'h01);
    rxc(8'hA5, 1'b0, 1'b0);
    rd(2'h2, 8'h2C, 8'h2C);
    rd(2'h3, 8'h5A, 8'hFF);
    rd(2'h2, 8'h00, 8'h2C);
    chk({7'h00, sciIrq}, 8'h00);
    rxc(8'h3C, 1'b0, 1'b1);
    rd(2'h2, 8'h22, 8'h2E);
    rd(2'h3, 8'h3C, 8'hFF);
  endtask

  // Line activity then a full character of ones
  task automatic idle_scn;
    goActive <= 1'b1;
    @(posedge clock);
    goActive <= 1'b0;
    repeat (220) @(posedge clock);
    rd(2'h2, 8'hD0, 8'hD0);
    chk({7'h00, sciIrq}, 8'h01);
    chk({6'h00, txPinOeN, txPinOut}, 8'h03);
  endtask

  // Re-enable, then one frame: start bit, LSB first, stop bit
  task automatic frame_scn;
    wr(2'h0, 8'h08);
    wr(2'h3, 8'hA6);
    n = 0;
    while (txPinOut !== 1'b0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    repeat (8) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      #1 chk({7'h00, txPinOut}, {7'h00, 1'({1'b1, 8'hA6, 1'b0} >> i)});
      repeat (16) @(posedge clock);
    end
  endtask

  // ----------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    finish_test;
  end

  initial begin
    {nrst, regWrite, regRead, goActive, rxCharValid, rxCharNoise} = 6'h00;
    {regAddr, regWrData, rxCharData, rxCharFrameErr} = 19'h00000;
    mismatches = 0;
    nTests = 0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    baud_chk(3'h0, 3'h0, 8'h01);
    baud_chk(3'h1, 3'h0, 8'h03);
    baud_chk(3'h2, 3'h1, 8'h08);
    baud_chk(3'h3, 3'h0, 8'h0D);
    baud_chk(3'h4, 3'h0, 8'h27);
    baud_chk(3'h0, 3'h7, 8'h80);
    wr(2'h1, 8'h00);
    rd(2'h2, 8'h00, 8'h10);
    tx_scn;
    rx_scn;
    idle_scn;
    frame_scn;
    finish_test;
  end
endmodule
